/* design/sdec_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants for the sinc4 decimator
// ----------------------------------------------------------------------------
package sdec_pkg;

	// ------------------------------------------------------------------------
	// clock and modulator timing
	// ------------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000; // REF_CLK rate
	localparam int unsigned CLK_PERIOD_NS = 40; // REF_CLK period
	localparam int unsigned PH_W = 25; // phase accumulator width, holds CLK_HZ + a rate
	localparam logic [PH_W-1:0] CLK_HZ_V = PH_W'(CLK_HZ);
	localparam int unsigned SAMPLES_PER_NOTCH = 256; // modulator rate over notch
	localparam int unsigned SAMPLES_PER_OUTPUT = 2048; // modulator rate over max output rate
	localparam logic [PH_W-1:0] RATE_50 = 25'd12800; // modulator rate, 50Hz notch
	localparam logic [PH_W-1:0] RATE_5060 = 25'd13960; // modulator rate, 50/60Hz mode
	localparam logic [PH_W-1:0] RATE_60 = 25'd15360; // modulator rate, 60Hz notch
	localparam int unsigned EXT_DIV = 20; // external clock edges per modulator sample
	localparam int unsigned EXT_REF_HZ = 307_200; // external clock that mimics 60Hz mode
	localparam int unsigned CONV_EXT_PERIODS = 41036; // conversion phase in external periods
	localparam int unsigned EXT_TAIL = CONV_EXT_PERIODS - SAMPLES_PER_OUTPUT * EXT_DIV;
	localparam int unsigned EXT_LOSS_DEFAULT = 8192; // idle cycles before external clock is dropped

	// ------------------------------------------------------------------------
	// filter geometry
	// ------------------------------------------------------------------------
	localparam int unsigned SINC_ORDER = 4;
	localparam int unsigned SINC_LEN = SAMPLES_PER_NOTCH; // boxcar length of each stage
	localparam int unsigned CONV_TICKS = SINC_LEN * SINC_ORDER; // one settled conversion
	localparam int unsigned CAL_TICKS = SAMPLES_PER_OUTPUT - CONV_TICKS; // offset phase
	localparam int unsigned ACC_W = 33; // 1 + 4*log2(256) bits of growth
	localparam logic [ACC_W-1:0] ACC_MID = 33'h080000000; // half of full sinc4 gain
	localparam int unsigned RAW_SHIFT = 8; // bits dropped from the centred sum
	localparam int unsigned RAW_W = ACC_W - RAW_SHIFT; // raw result width
	localparam int unsigned RES_W = RAW_W + 1; // delivered result width
	localparam int unsigned TICK_W = 11; // phase tick counter width
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned LVL_W = 5; // fifo level width

	// ------------------------------------------------------------------------
	// register map (APB, byte addresses)
	// ------------------------------------------------------------------------
	localparam int unsigned APB_AW = 8;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_DATA = 8'h08;
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_SPEED2X_BIT = 1;
	localparam int unsigned CTRL_DUAL_BIT = 2; // 50/60Hz instead of 50Hz while pin is high
	localparam int unsigned ST_AVAIL_BIT = 0;
	localparam int unsigned ST_EXT_BIT = 1;
	localparam int unsigned ST_OVERRUN_BIT = 2;
	localparam int unsigned ST_BUSY_BIT = 3;
	localparam int unsigned ST_LEVEL_LSB = 4;
	localparam int unsigned ST_NOTCH_LSB = 9;
	localparam int unsigned ST_SPEED_BIT = 11;

	// ------------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {NOTCH_50 = 2'h0, NOTCH_5060 = 2'h1, NOTCH_60 = 2'h2} sdec_notch_type;
	typedef enum {ST_IDLE, ST_CONV, ST_CAL, ST_TAIL, ST_PUSH} sdec_state_type;

endpackage : sdec_pkg

/* design/sdec_stream_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// valid/ready word stream between the filter and its result fifo
// ----------------------------------------------------------------------------
interface sdec_stream_if #(parameter int unsigned WIDTH = 8);
	logic valid; // word offered
	logic ready; // word accepted when both high
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sdec_stream_if

/* design/sdec_fifo.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// result fifo, register based
// ----------------------------------------------------------------------------
module sdec_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	sdec_stream_if.snk wr,
	sdec_stream_if.src rd,
	output logic [$clog2(DEPTH):0] level
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic do_wr;
	logic do_rd;

	// full and empty come straight from the level, so they never lie
	assign wr.ready = (level != (PW+1)'(DEPTH));
	assign rd.valid = (level != '0);
	assign rd.data = mem[rd_ptr];
	assign do_wr = wr.valid & wr.ready;
	assign do_rd = rd.valid & rd.ready;

	// write port
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= wr.data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level <= '0;
		end else if (do_wr && !do_rd) begin
			level <= level + 1'b1;
		end else if (do_rd && !do_wr) begin
			level <= level - 1'b1;
		end
	end

endmodule : sdec_fifo

/* design/sdec_filter.sv */
`timescale 1ns/1ps
// Overview of operation
// - modulator runs at 256 notch, 2048 max rate
// - internal rates 12800, 13960, 15360 Hz
// - external clock divided by 20 clocks modulator
// - fourth order sinc decimation of the bitstream
// - 2x speed skips offset calibration phase
// - 2x result is mean of last two raws
// - filter stays predictable up to 150% full scale
// - external conversion phase lasts 41036 periods
// - 307.2kHz external equals internal 60Hz mode
module sdec_filter #(
	parameter int unsigned EXT_LOSS_CYCLES = sdec_pkg::EXT_LOSS_DEFAULT
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [sdec_pkg::APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic OSC_SELECT_PIN,
	input wire logic MOD_BIT,
	output logic MOD_STROBE
);
	import sdec_pkg::*;

	localparam int unsigned LOSS_W = $clog2(EXT_LOSS_CYCLES) + 1;
	localparam int unsigned DIV_W = 5;
	localparam int unsigned TAIL_W = 8;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// modulator rate for each notch setting
	function automatic logic [PH_W-1:0] notch_rate(input sdec_notch_type n);
		logic [PH_W-1:0] r;
		r = RATE_60;
		unique case (n)
			NOTCH_50: r = RATE_50;
			NOTCH_5060: r = RATE_5060;
			NOTCH_60: r = RATE_60;
		endcase
		return r;
	endfunction : notch_rate

	// centre a full sinc4 sum around zero and drop low bits
	function automatic logic signed [RAW_W-1:0] to_raw(input logic [ACC_W-1:0] s);
		logic [ACC_W-1:0] c;
		c = s - ACC_MID;
		return $signed(c[ACC_W-1:RAW_SHIFT]);
	endfunction : to_raw

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	logic ctrl_enable; // software run switch
	logic ctrl_speed2x; // software 2x speed request
	logic ctrl_dual; // 50/60Hz instead of 50Hz
	logic overrun; // sticky: samples dropped while fifo full
	logic osc_pin_q; // previous pin level for edge detect
	logic ext_active; // external clock present on the select pin
	logic [LOSS_W-1:0] idle_cnt; // cycles since the last external edge
	logic [DIV_W-1:0] ext_div; // external edge divider
	logic [PH_W-1:0] phase; // internal rate accumulator
	logic [PH_W-1:0] next_phase;
	logic int_tick;
	logic ext_tick;
	logic ext_edge;
	logic mod_tick; // one modulator sample
	sdec_notch_type notch; // notch in force
	sdec_state_type state;
	logic speed_q; // speed mode latched for the frame
	logic [TICK_W-1:0] tick_cnt; // samples in the current phase
	logic [TAIL_W-1:0] tail_cnt; // external periods in the tail
	logic [ACC_W-1:0] integ [SINC_ORDER]; // integrator chain
	logic [ACC_W-1:0] dly [SINC_ORDER]; // comb delays
	logic [ACC_W-1:0] next_integ [SINC_ORDER];
	logic [ACC_W-1:0] comb [SINC_ORDER];
	logic sinc_done; // last sample of a settled window
	logic signed [RAW_W-1:0] conv_raw; // conversion phase result
	logic signed [RAW_W-1:0] prev_raw; // previous raw, 2x mode
	logic have_prev;
	logic signed [RES_W-1:0] result; // word waiting for the fifo
	logic signed [RES_W-1:0] next_avg;
	logic [LVL_W-1:0] fifo_level;
	logic apb_setup;
	logic apb_access;
	logic addr_ok;

	sdec_stream_if #(.WIDTH(RES_W)) push_if ();
	sdec_stream_if #(.WIDTH(RES_W)) pop_if ();

	// ------------------------------------------------------------------------
	// sample clock generation
	// ------------------------------------------------------------------------
	// the party holds the pin low for 60Hz; high picks 50 or 50/60 from control
	always_comb begin
		if (!OSC_SELECT_PIN) begin
			notch = NOTCH_60;
		end else if (ctrl_dual) begin
			notch = NOTCH_5060;
		end else begin
			notch = NOTCH_50;
		end
	end

	// fractional divider keeps the exact average rate from a 25MHz clock
	always_comb begin
		next_phase = phase + notch_rate(notch);
		int_tick = 1'b0;
		if (next_phase >= CLK_HZ_V) begin
			next_phase = next_phase - CLK_HZ_V;
			int_tick = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase <= '0;
		end else begin
			phase <= next_phase;
		end
	end

	assign ext_edge = OSC_SELECT_PIN & ~osc_pin_q;

	// a toggling pin means an external clock; silence drops back to internal
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			osc_pin_q <= 1'b1; // high: a pin held high through reset is no false edge
			ext_active <= 1'b0;
			idle_cnt <= '0;
		end else begin
			osc_pin_q <= OSC_SELECT_PIN;
			if (ext_edge) begin
				ext_active <= 1'b1;
				idle_cnt <= '0;
			end else if (idle_cnt == LOSS_W'(EXT_LOSS_CYCLES - 1)) begin
				ext_active <= 1'b0;
			end else begin
				idle_cnt <= idle_cnt + 1'b1;
			end
		end
	end

	// every twentieth external edge is one modulator sample
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ext_div <= '0;
		end else if (ext_edge) begin
			ext_div <= (ext_div == DIV_W'(EXT_DIV - 1)) ? '0 : ext_div + 1'b1;
		end
	end

	assign ext_tick = ext_edge & (ext_div == DIV_W'(EXT_DIV - 1));
	assign mod_tick = ext_active ? ext_tick : int_tick;

	// strobe to the modulator, only while a phase consumes samples
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MOD_STROBE <= 1'b0;
		end else begin
			MOD_STROBE <= mod_tick & ((state == ST_CONV) | (state == ST_CAL));
		end
	end

	// ------------------------------------------------------------------------
	// sinc4 datapath
	// ------------------------------------------------------------------------
	// integrators wrap modulo 2^33 and the combs undo it exactly, so even an
	// overranged bit density gives a bounded, repeatable result
	always_comb begin
		next_integ[0] = integ[0] + ACC_W'(MOD_BIT);
		for (int k = 1; k < SINC_ORDER; k++) begin
			next_integ[k] = integ[k] + next_integ[k-1];
		end
		comb[0] = next_integ[SINC_ORDER-1] - dly[0];
		for (int k = 1; k < SINC_ORDER; k++) begin
			comb[k] = comb[k-1] - dly[k];
		end
	end

	// the window closes on the last sample of a settled conversion
	assign sinc_done = mod_tick & (tick_cnt == TICK_W'(CONV_TICKS - 1));

	// integrators and combs, cleared whenever neither the conversion nor the offset phase runs
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int k = 0; k < SINC_ORDER; k++) begin
				integ[k] <= '0;
				dly[k] <= '0;
			end
		end else if ((state == ST_CONV) || (state == ST_CAL)) begin
			if (mod_tick) begin
				integ <= next_integ;
				if (tick_cnt[7:0] == 8'hff) begin
					dly[0] <= next_integ[SINC_ORDER-1];
					for (int k = 1; k < SINC_ORDER; k++) begin
						dly[k] <= comb[k-1];
					end
				end
			end
		end else begin
			for (int k = 0; k < SINC_ORDER; k++) begin
				integ[k] <= '0;
				dly[k] <= '0;
			end
		end
	end

	// full precision sum, then one arithmetic shift
	assign next_avg = RES_W'((RES_W'(prev_raw) + RES_W'(to_raw(comb[SINC_ORDER-1]))) >>> 1);

	// ------------------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= ST_IDLE;
			speed_q <= 1'b0;
			tick_cnt <= '0;
			tail_cnt <= '0;
			conv_raw <= '0;
			prev_raw <= '0;
			have_prev <= 1'b0;
			result <= '0;
		end else if (!ctrl_enable && (state != ST_PUSH)) begin
			// stopping mid frame drops it; a pending word still goes out
			state <= ST_IDLE;
			tick_cnt <= '0;
			have_prev <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					speed_q <= ctrl_speed2x;
					tick_cnt <= '0;
					tail_cnt <= '0;
					state <= ST_CONV;
				end
				ST_CONV: begin
					if (mod_tick) begin
						tick_cnt <= tick_cnt + 1'b1;
					end
					if (sinc_done) begin
						tick_cnt <= '0;
						if (speed_q) begin
							// no offset phase: one result per raw after the first
							prev_raw <= to_raw(comb[SINC_ORDER-1]);
							have_prev <= 1'b1;
							result <= next_avg;
							state <= have_prev ? ST_PUSH : ST_CONV;
						end else begin
							conv_raw <= to_raw(comb[SINC_ORDER-1]);
							state <= ST_CAL;
						end
					end
				end
				ST_CAL: begin
					if (mod_tick) begin
						tick_cnt <= tick_cnt + 1'b1;
					end
					// offset phase takes the rest of the 2048 sample frame
					if (mod_tick && (tick_cnt == TICK_W'(CAL_TICKS - 1))) begin
						tick_cnt <= '0;
						result <= RES_W'(conv_raw) - RES_W'(to_raw(comb[SINC_ORDER-1]));
						state <= ext_active ? ST_TAIL : ST_PUSH;
					end
				end
				ST_TAIL: begin
					// stretch the phase to 41036 external periods
					if (ext_edge) begin
						tail_cnt <= tail_cnt + 1'b1;
					end
					if (!ext_active || (ext_edge && (tail_cnt == TAIL_W'(EXT_TAIL - 1)))) begin
						tail_cnt <= '0;
						state <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					// a full fifo holds the sequencer here
					if (push_if.ready) begin
						speed_q <= ctrl_speed2x;
						have_prev <= have_prev & (speed_q == ctrl_speed2x);
						state <= ctrl_enable ? ST_CONV : ST_IDLE;
					end
				end
			endcase
		end
	end

	assign push_if.valid = (state == ST_PUSH);
	assign push_if.data = result;

	// ------------------------------------------------------------------------
	// result fifo
	// ------------------------------------------------------------------------
	sdec_fifo #(
		.WIDTH(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(REF_CLK),
		.reset_n(RESET_N),
		.wr(push_if.snk),
		.rd(pop_if.src),
		.level(fifo_level)
	);

	// ------------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------------
	assign apb_setup = PSEL & ~PENABLE;
	assign apb_access = PSEL & PENABLE;
	assign addr_ok = (PADDR == ADDR_CTRL) | (PADDR == ADDR_STATUS) | (PADDR == ADDR_DATA);
	assign PREADY = 1'b1; // zero wait states
	assign PSLVERR = apb_access & ~addr_ok;
	// a data read completes and pops the word captured during setup
	assign pop_if.ready = apb_access & ~PWRITE & (PADDR == ADDR_DATA);

	// control register
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_enable <= 1'b0;
			ctrl_speed2x <= 1'b0;
			ctrl_dual <= 1'b0;
		end else if (apb_access && PWRITE && (PADDR == ADDR_CTRL)) begin
			ctrl_enable <= PWDATA[CTRL_ENABLE_BIT];
			ctrl_speed2x <= PWDATA[CTRL_SPEED2X_BIT];
			ctrl_dual <= PWDATA[CTRL_DUAL_BIT];
		end
	end

	// overrun: a sample while stalled sets it, writing one clears, set wins
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			overrun <= 1'b0;
		end else if ((state == ST_PUSH) && !push_if.ready && mod_tick) begin
			overrun <= 1'b1;
		end else if (apb_access && PWRITE && (PADDR == ADDR_STATUS) && PWDATA[ST_OVERRUN_BIT]) begin
			overrun <= 1'b0;
		end
	end

	// read data is captured in the setup cycle so it stands as a flop output
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PRDATA <= '0;
		end else if (apb_setup && !PWRITE) begin
			PRDATA <= '0;
			unique case (PADDR)
				ADDR_CTRL: begin
					PRDATA[CTRL_ENABLE_BIT] <= ctrl_enable;
					PRDATA[CTRL_SPEED2X_BIT] <= ctrl_speed2x;
					PRDATA[CTRL_DUAL_BIT] <= ctrl_dual;
				end
				ADDR_STATUS: begin
					PRDATA[ST_AVAIL_BIT] <= pop_if.valid;
					PRDATA[ST_EXT_BIT] <= ext_active;
					PRDATA[ST_OVERRUN_BIT] <= overrun;
					PRDATA[ST_BUSY_BIT] <= (state != ST_IDLE);
					PRDATA[ST_LEVEL_LSB +: LVL_W] <= fifo_level;
					PRDATA[ST_NOTCH_LSB +: 2] <= notch;
					PRDATA[ST_SPEED_BIT] <= speed_q;
				end
				ADDR_DATA: begin
					if (pop_if.valid) begin
						PRDATA <= 32'(signed'(pop_if.data));
					end
				end
				default: begin
					PRDATA <= '0;
				end
			endcase
		end
	end

endmodule : sdec_filter

/* sim/sdec_mod_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// modulator bitstream model
// ----------------------------------------------------------------------------
module sdec_mod_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic restart, // clears the sample count before a frame
	input wire logic level, // constant input bit during conversion
	input wire logic mod_strobe, // one pulse per consumed sample
	output logic mod_bit,
	output logic [15:0] count // samples consumed since restart
);
	// ------------------------------------------------------------------------
	// sample counter
	// ------------------------------------------------------------------------
	// counts strobes so the model knows which phase the next bit belongs to
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 16'h0;
		end else if (restart) begin
			count <= 16'h0;
		end else if (mod_strobe) begin
			count <= count + 16'h1;
		end
	end
	// ------------------------------------------------------------------------
	// bit source
	// ------------------------------------------------------------------------
	// second block of 1024 samples is a zero-input pattern: alternating bits
	// average out exactly over every even boxcar, so its raw is exactly zero
	assign mod_bit = count[10] ? count[0] : level;
endmodule : sdec_mod_model

/* sim/sdec_filter_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// port checks for the decimator
// ----------------------------------------------------------------------------
module sdec_filter_mon #(
	parameter int unsigned EXT_LOSS_CYCLES = sdec_pkg::EXT_LOSS_DEFAULT
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [sdec_pkg::APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic OSC_SELECT_PIN,
	input wire logic MOD_BIT,
	input wire logic MOD_STROBE
);
	import sdec_pkg::*;
	logic [2:0] ctrl; // shadow of the control bits
	logic pin_q; // pin one cycle ago
	logic [7:0] edges; // pin rising edges since last strobe, saturating
	logic unmapped; // address outside the map
	assign unmapped = !(PADDR inside {ADDR_CTRL, ADDR_STATUS, ADDR_DATA});
	// ------------------------------------------------------------------------
	// helper state
	// ------------------------------------------------------------------------
	// shadow follows completed writes only
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl <= 3'h0;
		end else if (PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL) begin
			ctrl <= PWDATA[2:0];
		end
	end
	// pin edge count; reset high like the design's detector, so a held level is no edge
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pin_q <= 1'b1;
			edges <= 8'h0;
		end else begin
			pin_q <= OSC_SELECT_PIN;
			if (MOD_STROBE) begin
				edges <= 8'h0;
			end else if (OSC_SELECT_PIN && !pin_q && edges != 8'hff) begin
				edges <= edges + 8'h1;
			end
		end
	end
	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	ready_const_a: assert property (PREADY)
		else $error("ready dropped");
	err_unmapped_a: assert property (PSEL && PENABLE && unmapped |-> PSLVERR)
		else $error("no error on unmapped access");
	err_quiet_a: assert property (!(PSEL && PENABLE && unmapped) |-> !PSLVERR)
		else $error("spurious error response");
	rd_unmapped_a: assert property (PSEL && PENABLE && !PWRITE && unmapped |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	ctrl_back_a: assert property (PSEL && PENABLE && !PWRITE && PADDR == ADDR_CTRL
		|-> PRDATA[2:0] == ctrl) else $error("control readback wrong");
	strobe_pulse_a: assert property (MOD_STROBE |=> !MOD_STROBE [*8])
		else $error("strobes too close");
	strobe_off_a: assert property (!ctrl[0] [*3] |-> !MOD_STROBE)
		else $error("strobe while disabled");
	ext_edges_a: assert property (MOD_STROBE |-> edges == 8'h0 || edges >= 8'd20)
		else $error("external sample after too few edges");
endmodule : sdec_filter_mon

bind sdec_filter sdec_filter_mon #(.EXT_LOSS_CYCLES(EXT_LOSS_CYCLES)) u_mon (
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.OSC_SELECT_PIN(OSC_SELECT_PIN), .MOD_BIT(MOD_BIT), .MOD_STROBE(MOD_STROBE));

/* sim/sdec_filter_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// bench for the sinc4 decimator
// ----------------------------------------------------------------------------
module sdec_filter_tb;
	import sdec_pkg::*;
	localparam int LOSS = 64; // short clock-loss window, edges come every 2 cycles
	localparam int LIMIT = 230000; // two full external frames dominate the run
	localparam longint FS = longint'(ACC_MID) >>> RAW_SHIFT; // full-scale raw
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pin = 1, ext = 0;
	logic lvl = 0, restart = 1, pready, pslverr, mbit, mstb;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [15:0] mcnt;
	logic [63:0] e; // expected value and mask of one read
	logic [63:0] q[$];
	int fails = 0, total_checks = 0, cyc = 0;
	sdec_filter #(.EXT_LOSS_CYCLES(LOSS)) dut (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .OSC_SELECT_PIN(pin), .MOD_BIT(mbit),
		.MOD_STROBE(mstb));
	sdec_mod_model u_mod (.clk(clk), .reset_n(rst_n), .restart(restart), .level(lvl),
		.mod_strobe(mstb), .mod_bit(mbit), .count(mcnt));
	// ------------------------------------------------------------------------
	// clock, external pin toggling, timeout
	// ------------------------------------------------------------------------
	initial begin
		forever #20 clk = ~clk;
	end
	// fastest external clock the edge detector can follow
	always @(posedge clk) begin
		if (ext) begin
			pin <= ~pin;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			close_out();
		end
	end
	// ------------------------------------------------------------------------
	// checking
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// read watcher: takes the oldest note at every completed read
	always @(posedge clk) begin
		if (psel && pen && pready === 1'b1 && !pwr) begin
			e = q.pop_front();
			if (e[31:0] != 32'h0) begin
				chk(prdata & e[31:0], e[63:32]);
			end
		end
	end
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// ------------------------------------------------------------------------
	// apb master
	// ------------------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= w ? d : 32'h0;
		if (!w) begin
			q.push_back({d & m, m});
		end
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	// polls status until a result waits in the fifo
	task automatic wait_avail();
		do apb(1'b0, ADDR_STATUS, 32'h0, 32'h0); while (r[ST_AVAIL_BIT] !== 1'b1);
	endtask : wait_avail
	// measures one strobe interval; internal divider may jitter by one cycle
	task automatic gap(input int lo, input int hi);
		int n;
		n = 0;
		do @(posedge clk); while (mstb !== 1'b1);
		do begin
			@(posedge clk);
			n++;
		end while (mstb !== 1'b1);
		chk(n, (n == hi) ? hi : lo);
	endtask : gap
	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		static logic [PH_W-1:0] rate[3] = '{RATE_50, RATE_5060, RATE_60};
		static logic [1:0] notch[3] = '{NOTCH_50, NOTCH_5060, NOTCH_60};
		logic [7:0] bad;
		int lo;
		lo = $urandom(11);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0, 32'h7);
		apb(1'b1, ADDR_CTRL, 32'h6, 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h6, 32'h7);
		// unmapped write is dropped, read returns zero
		bad = {$urandom_range(63, 3), 2'b00};
		apb(1'b1, bad, $urandom, 32'h0);
		apb(1'b0, bad, 32'h0, 32'hffffffff);
		apb(1'b0, ADDR_CTRL, 32'h6, 32'h7);
		// internal notches; pin high modes first, then low for 60Hz
		for (int i = 0; i < 3; i++) begin
			pin <= (i < 2);
			lo = CLK_HZ / int'(rate[i]);
			apb(1'b1, ADDR_CTRL, {29'h0, i == 1, 2'b01}, 32'h0);
			gap(lo, lo + 1);
			gap(lo, lo + 1);
			apb(1'b0, ADDR_STATUS, {21'h0, notch[i], 9'h0}, 32'h602);
			apb(1'b1, ADDR_CTRL, 32'h0, 32'h0);
		end
		// external clock, 1x frame with full-scale ones
		ext <= 1'b1;
		lvl <= 1'b1;
		repeat (200) @(posedge clk);
		apb(1'b0, ADDR_STATUS, 32'h2, 32'h9ff);
		apb(1'b1, ADDR_CTRL, 32'h1, 32'h0);
		restart <= 1'b0;
		gap(2 * EXT_DIV, 2 * EXT_DIV);
		wait_avail();
		chk(mcnt, SAMPLES_PER_OUTPUT);
		apb(1'b0, ADDR_DATA, 32'(FS), 32'hffffffff);
		apb(1'b0, ADDR_DATA, 32'h0, 32'hffffffff);
		// 2x frames, zeros then the alternating pattern: first raw gives nothing, then an average
		apb(1'b1, ADDR_CTRL, 32'h0, 32'h0);
		restart <= 1'b1;
		lvl <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h3, 32'h0);
		restart <= 1'b0;
		wait_avail();
		chk(mcnt, 2 * CONV_TICKS);
		apb(1'b0, ADDR_DATA, 32'(-FS / 2), 32'hffffffff);
		close_out();
	end
endmodule : sdec_filter_tb
